// ==== hw/spf_port.sv ====
// Serial port: format and framing control, shift engine and word buffers
// Functional notes
// - Clock pin release stops driving the serial clock pin in master mode.
// - Data-out pin release leaves the serial data output undriven.
// - Word width select picks 16-bit words, else 8-bit bytes.
// - Master samples input at end of bit period when late sampling set.
// - Output edge select moves data change to active-to-idle clock edge, except in framed mode.
// - Slave with select enabled obeys active-low select pin, else ignores it.
// - Idle-high polarity makes the clock idle high, active low.
// - Controller mode makes the port the clock master, else a slave.
// - Framed mode turns the select pin into a frame sync pulse.
// - Sync direction set: sync is an input; clear: port drives it.
// - Sync polarity set: pulse active high; clear: active low.
// - Sync coincide: pulse on first bit clock, else one clock earlier.
// - Deep buffer enable selects multi-entry buffering, else single word.
// - Unused control bits read back as zero.
// - Port enable claims the link pins; clear disables the port.
// - Enhanced buffering holds eight words each way.
// - Framed mode runs the clock continuously; sync marks each frame start.
//
// Decided for this implementation: the address map and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none
`include "spf_defines.svh"

module spf_port
  import spf_pkg::*;
#(
  parameter int DEPTH = `SPF_DEEP_DEPTH
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [`SPF_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Link pins, output enables low while driving
  input wire spf_pins_s pin_in,
  output spf_pins_s pin_out,
  output spf_pins_s pin_oe_n
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  // ==========================================================
  // Registers and state
  spf_format_s fmt;
  spf_frame_s frm;
  logic port_enable;
  logic rx_overflow;
  spf_state_e state;
  spf_state_e next_state;
  logic [4:0] edge_idx;
  logic [15:0] tx_shift;
  logic [15:0] rx_shift;
  logic [9:0] half_cnt;
  logic sck_act;
  logic fsync_act;
  spf_pins_s pin_meta;
  spf_pins_s pin_sync;
  logic act_prev;
  logic [15:0] tx_mem [DEPTH];
  logic [15:0] rx_mem [DEPTH];
  logic [PW-1:0] tx_rd;
  logic [PW-1:0] tx_wr;
  logic [PW-1:0] rx_rd;
  logic [PW-1:0] rx_wr;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;

  // ==========================================================
  // Mode decode
  wire logic master = fmt.controller_mode;
  wire logic framed = frm.framed_enable;
  wire logic cke = fmt.output_edge_select & ~framed;
  wire logic late = fmt.input_sample_late & master;
  wire logic fs_drive = framed & ~frm.sync_direction;
  wire logic fs_recv = framed & frm.sync_direction;
  wire logic [4:0] nbits = fmt.word_width_select ?
    `SPF_WIDE_BITS : `SPF_NARROW_BITS;
  wire logic [5:0] last_edge = {nbits, 1'h0} - 6'h01;
  wire logic [CW-1:0] cap = frm.deep_buffer_enable ?
    CW'(DEPTH) : CW'(`SPF_STD_DEPTH);

  // ==========================================================
  // Pin synchronisers: only the second stage is read by logic
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  wire logic slv_act = pin_sync.clk ^ fmt.idle_high_polarity;
  wire logic ss_in = pin_sync.sel;
  wire logic selected = ~fmt.select_pin_enable | ~ss_in;
  wire logic fsync_in = ~(ss_in ^ frm.sync_polarity);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_prev <= 1'h0;
    end else begin
      act_prev <= slv_act;
    end
  end

  // ==========================================================
  // Master clock divider
  // An odd ratio gives the longer half to idle; ratio one is guarded to two
  wire logic [9:0] ratio = (10'h001 << {fmt.primary_divider ^ 2'h3, 1'h0})
    * (`SPF_SEC_BASE - {7'h00, fmt.secondary_divider});
  wire logic [9:0] half_act = (ratio >> 1) | {9'h000, ratio == 10'h001};
  wire logic [9:0] half_idle = ratio - (ratio >> 1);
  wire logic div_run = port_enable & master &
    (framed | state != SPF_IDLE);
  wire logic div_lead = div_run & ~sck_act &
    (half_cnt == half_idle - 10'h001);
  wire logic div_trail = div_run & sck_act &
    (half_cnt == half_act - 10'h001);

  always_ff @(posedge core_clk) begin
    if (srst || !div_run) begin
      half_cnt <= 10'h000;
      sck_act <= 1'h0;
    end else if (div_lead || div_trail) begin
      half_cnt <= 10'h000;
      sck_act <= div_lead;
    end else begin
      half_cnt <= half_cnt + 10'h001;
    end
  end

  // Leading is idle-to-active, trailing is active-to-idle
  wire logic lead_ev = master ? div_lead :
    port_enable & slv_act & ~act_prev;
  wire logic trail_ev = master ? div_trail :
    port_enable & ~slv_act & act_prev;

  // ==========================================================
  // Word start, frame sync and abort
  wire logic idle = state == SPF_IDLE;
  wire logic tx_avail = tx_cnt != '0;
  wire logic st_master = idle & port_enable & master & ~framed & tx_avail;
  wire logic st_fout = idle & fs_drive & trail_ev & tx_avail;
  wire logic st_fin_pre = idle & fs_recv & lead_ev & fsync_in &
    ~frm.sync_coincide;
  wire logic imm_start = lead_ev & (
    (idle & ~master & ~framed & selected) |
    (idle & fs_recv & fsync_in & frm.sync_coincide) |
    (state == SPF_PRE & fs_recv));
  wire logic start_word = st_master | st_fout | st_fin_pre |
    (imm_start & idle);
  wire logic abort = ~master & ~framed & fmt.select_pin_enable & ss_in &
    ~idle;

  always_ff @(posedge core_clk) begin
    if (srst || !port_enable || !fs_drive) begin
      fsync_act <= 1'h0;
    end else if (st_fout) begin
      fsync_act <= 1'h1;
    end else if (trail_ev && (state == SPF_PRE ||
        (state == SPF_SHIFT && edge_idx == 5'h01))) begin
      fsync_act <= 1'h0;
    end
  end

  // ==========================================================
  // Shift engine: edges of a word are numbered from 0, leading first
  wire logic eng = (state == SPF_SHIFT & (lead_ev | trail_ev)) | imm_start;
  wire logic last = edge_idx == last_edge[4:0];
  wire logic nz = edge_idx != 5'h00;
  wire logic mid_cap = cke ? lead_ev : trail_ev;
  wire logic late_cap = cke ? trail_ev :
    (lead_ev & nz) | (trail_ev & last);
  wire logic capture = eng & (late ? late_cap : mid_cap);
  wire logic launch = eng & ~last &
    (cke ? trail_ev : lead_ev & nz);
  wire logic [15:0] next_rx = capture ?
    {rx_shift[14:0], pin_sync.dat} : rx_shift;
  wire logic word_done = eng & last;
  wire logic [15:0] rx_word = fmt.word_width_select ?
    next_rx : {8'h00, next_rx[7:0]};
  wire logic [15:0] tx_head = tx_mem[tx_rd];
  wire logic [15:0] tx_load = ~tx_avail ? 16'h0000 :
    fmt.word_width_select ? tx_head : {tx_head[7:0], 8'h00};

  always_comb begin
    next_state = state;
    case (state)
      SPF_IDLE: begin
        if (st_master || (st_fout && frm.sync_coincide)) begin
          next_state = SPF_SHIFT;
        end else if (st_fout || st_fin_pre) begin
          next_state = SPF_PRE;
        end else if (eng) begin
          next_state = SPF_SHIFT;
        end
      end
      SPF_PRE: begin
        if (eng || (fs_drive && trail_ev)) begin
          next_state = SPF_SHIFT;
        end
      end
      SPF_SHIFT: begin
        if (word_done || abort) begin
          next_state = SPF_IDLE;
        end
      end
      default: begin
        next_state = SPF_IDLE;
      end
    endcase
    if (!port_enable) begin
      next_state = SPF_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= SPF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || abort || !port_enable || (!eng && state != SPF_SHIFT)) begin
      edge_idx <= 5'h00;
    end else if (eng) begin
      edge_idx <= last ? 5'h00 : edge_idx + 5'h01;
    end
  end

  // The outgoing word is kept on the line while idle so that the first
  // bit is valid before the first clock edge in every mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
    end else begin
      if (idle) begin
        tx_shift <= tx_load;
      end else if (launch) begin
        tx_shift <= {tx_shift[14:0], 1'h0};
      end
      rx_shift <= next_rx;
    end
  end

  // ==========================================================
  // Word buffers
  wire logic tx_full = tx_cnt >= cap;
  wire logic rx_full = rx_cnt >= cap;
  wire logic wr_data = reg_wr & reg_addr == `SPF_OFS_DATA;
  wire logic rd_data = reg_rd & reg_addr == `SPF_OFS_DATA;
  wire logic tx_push = wr_data & ~tx_full;
  wire logic tx_pop = start_word & tx_avail;
  wire logic rx_push = word_done & ~rx_full;
  wire logic rx_pop = rd_data & rx_cnt != '0;

  always_ff @(posedge core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr] <= reg_wdata;
    end
    if (rx_push) begin
      rx_mem[rx_wr] <= rx_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_rd <= '0;
      tx_wr <= '0;
      tx_cnt <= '0;
      rx_rd <= '0;
      rx_wr <= '0;
      rx_cnt <= '0;
    end else begin
      tx_wr <= tx_wr + PW'(tx_push);
      tx_rd <= tx_rd + PW'(tx_pop);
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
      rx_wr <= rx_wr + PW'(rx_push);
      rx_rd <= rx_rd + PW'(rx_pop);
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // ==========================================================
  // Register port
  wire logic wr_stat = reg_wr & reg_addr == `SPF_OFS_STATUS;
  wire logic [15:0] stat_word = {port_enable, 3'h0, 4'(tx_cnt), idle,
    rx_overflow, rx_cnt == '0, 3'h0, tx_full, rx_full};
  wire logic [15:0] rd_mux =
    reg_addr == `SPF_OFS_FORMAT ? fmt :
    reg_addr == `SPF_OFS_FRAME ? frm :
    reg_addr == `SPF_OFS_STATUS ? stat_word :
    rx_cnt != '0 ? rx_mem[rx_rd] : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fmt <= spf_format_s'(`SPF_FORMAT_RST);
      frm <= spf_frame_s'(`SPF_FRAME_RST);
      port_enable <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == `SPF_OFS_FORMAT) begin
        fmt <= spf_format_s'(reg_wdata & `SPF_FORMAT_WMASK);
      end
      if (reg_wr && reg_addr == `SPF_OFS_FRAME) begin
        frm <= spf_frame_s'(reg_wdata & `SPF_FRAME_WMASK);
      end
      if (wr_stat) begin
        port_enable <= reg_wdata[`SPF_STAT_EN_BIT];
      end
    end
  end

  // A lost word in the same cycle as a clear keeps the flag set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_overflow <= 1'h0;
    end else if (word_done && rx_full) begin
      rx_overflow <= 1'h1;
    end else if (wr_stat && !reg_wdata[`SPF_STAT_OVF_BIT]) begin
      rx_overflow <= 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Pin drive
  assign pin_out.clk = sck_act ^ fmt.idle_high_polarity;
  assign pin_oe_n.clk = ~(port_enable & master &
    ~fmt.clock_pin_release);
  assign pin_out.dat = tx_shift[15];
  assign pin_oe_n.dat = ~(port_enable & ~fmt.data_out_pin_release &
    (master | framed | selected));
  assign pin_out.sel = ~(fsync_act ^ frm.sync_polarity);
  assign pin_oe_n.sel = ~(port_enable & fs_drive);

endmodule : spf_port

`default_nettype wire

// ==== hw/spf_defines.svh ====
// Register offsets, field positions, reset values and counts of the serial port
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

`define SPF_ADDR_W 2
`define SPF_OFS_FORMAT 2'h0
`define SPF_OFS_FRAME 2'h1
`define SPF_OFS_STATUS 2'h2
`define SPF_OFS_DATA 2'h3

`define SPF_FORMAT_RST 16'h0000
`define SPF_FRAME_RST 16'h0000
`define SPF_FORMAT_WMASK 16'h1fff
`define SPF_FRAME_WMASK 16'he003

`define SPF_STAT_EN_BIT 15
`define SPF_STAT_OVF_BIT 6

`define SPF_DEEP_DEPTH 8
`define SPF_STD_DEPTH 1
`define SPF_WIDE_BITS 5'h10
`define SPF_NARROW_BITS 5'h08
`define SPF_SEC_BASE 10'h008

`endif

// ==== hw/spf_pkg.sv ====
// Types shared by the serial port design and its bench
package spf_pkg;

  // First control register, bit 15 down to bit 0
  typedef struct packed {
    logic [2:0] unused;
    logic clock_pin_release;
    logic data_out_pin_release;
    logic word_width_select;
    logic input_sample_late;
    logic output_edge_select;
    logic select_pin_enable;
    logic idle_high_polarity;
    logic controller_mode;
    logic [2:0] secondary_divider;
    logic [1:0] primary_divider;
  } spf_format_s;

  // Second control register, bit 15 down to bit 0
  typedef struct packed {
    logic framed_enable;
    logic sync_direction;
    logic sync_polarity;
    logic [10:0] unused;
    logic sync_coincide;
    logic deep_buffer_enable;
  } spf_frame_s;

  // Link pins: clk is the serial clock, dat is data, sel is select or sync
  typedef struct packed {
    logic clk;
    logic dat;
    logic sel;
  } spf_pins_s;

  typedef enum logic [1:0] {
    SPF_IDLE = 2'h0,
    SPF_PRE = 2'h1,
    SPF_SHIFT = 2'h3
  } spf_state_e;

endpackage : spf_pkg

// ==== verif/spf_port_assertions.sv ====
// Checker for the serial port control bits and pin ownership
`timescale 1ns/1ps
`default_nettype none
`include "spf_defines.svh"
module spf_port_assertions
  import spf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [`SPF_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Link pins
  input wire spf_pins_s pin_in,
  input wire spf_pins_s pin_out,
  input wire spf_pins_s pin_oe_n
);
  // ==========
  // Shadow of the control bits, kept from the write strobes alone
  spf_format_s fmt;
  spf_frame_s frm;
  logic en;
  wire logic wr_fmt = reg_wr && reg_addr == `SPF_OFS_FORMAT;
  wire logic wr_frm = reg_wr && reg_addr == `SPF_OFS_FRAME;
  wire logic wr_st = reg_wr && reg_addr == `SPF_OFS_STATUS;
  wire logic rd_fmt = reg_rd && reg_addr == `SPF_OFS_FORMAT;
  wire logic rd_frm = reg_rd && reg_addr == `SPF_OFS_FRAME;
  wire logic master = en && fmt.controller_mode;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fmt <= '0;
      frm <= '0;
      en <= 1'b0;
    end else begin
      if (wr_fmt) fmt <= reg_wdata & `SPF_FORMAT_WMASK;
      if (wr_frm) frm <= reg_wdata & `SPF_FRAME_WMASK;
      if (wr_st) en <= reg_wdata[`SPF_STAT_EN_BIT];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ==========
  // Properties
  a_format_back: assert property (
    $past(rd_fmt) |-> reg_rdata == $past(fmt))
    else $error("format read back differs");
  a_frame_back: assert property (
    $past(rd_frm) |-> reg_rdata == $past(frm))
    else $error("frame read back differs");
  a_off_released: assert property (!en |-> pin_oe_n == 3'h7)
    else $error("disabled port drives a pin");
  a_clk_release: assert property (
    master && fmt.clock_pin_release |-> pin_oe_n.clk)
    else $error("released clock pin still driven");
  a_clk_driven: assert property (
    master && !fmt.clock_pin_release |-> !pin_oe_n.clk)
    else $error("master does not drive its clock");
  a_slave_clk: assert property (
    en && !fmt.controller_mode |-> pin_oe_n.clk)
    else $error("slave drives the clock pin");
  a_dat_release: assert property (
    fmt.data_out_pin_release |-> pin_oe_n.dat)
    else $error("released data pin still driven");
  a_sync_dir: assert property (
    en && frm.framed_enable |-> pin_oe_n.sel == frm.sync_direction)
    else $error("sync pin direction wrong");
endmodule : spf_port_assertions
bind spf_port spf_port_assertions spf_port_assertions_i (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n)
);
`default_nettype wire

// ==== verif/spf_far_end.sv ====
// Far-end serial peripheral answering the port in master operation
`timescale 1ns/1ps
`default_nettype none
module spf_far_end (
  // Link
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Setup from the bench
  input wire logic cpol,
  input wire logic cke,
  input wire logic load,
  input wire logic [15:0] word,
  output logic [15:0] rx
);
  // ==========
  // Shifter; spent bits are refilled inverted so a late sample shows
  logic [15:0] sr = 16'h0000;
  logic q = 1'b0;
  assign miso = cke ? sr[15] : q;
  always @(sck or posedge load) begin
    if (load) begin
      sr <= word;
      q <= ~word[15];
      rx <= 16'h0000;
    end else if ((sck != cpol) == cke) begin
      rx <= {rx[14:0], mosi};
    end else if (cke) begin
      sr <= {sr[14:0], ~sr[15]};
    end else begin
      q <= sr[15];
      sr <= {sr[14:0], ~sr[15]};
    end
  end
endmodule : spf_far_end
`default_nettype wire

// ==== verif/spf_port_bench.sv ====
// Self-checking bench for the serial port in master operation
`timescale 1ns/1ps
`default_nettype none
`include "spf_defines.svh"
module spf_port_bench
  import spf_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [`SPF_ADDR_W-1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  spf_pins_s pin_in, pin_out, pin_oe_n;
  logic cpol = 1'b0;
  logic cke = 1'b0;
  logic load = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [15:0] rx;
  logic miso;
  logic [31:0] seed = 32'h4ccc_3136;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  // Undriven clock rests idle; released data and select pull up
  wire logic sck = pin_oe_n.clk ? cpol : pin_out.clk;
  wire logic mosi = pin_oe_n.dat ? 1'b1 : pin_out.dat;
  wire logic sel = pin_oe_n.sel ? 1'b1 : pin_out.sel;
  assign pin_in = {sck, miso, sel};
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  spf_port spf_port_i (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );
  spf_far_end spf_far_end_i (
    .sck(sck), .mosi(mosi), .miso(miso), .cpol(cpol), .cke(cke),
    .load(load), .word(word), .rx(rx)
  );
  // ==========
  // Report, compare and bus tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  function automatic logic [15:0] ratio(input logic [1:0] p,
      input logic [2:0] s);
    return 16'((16'h0001 << (2 * (3 - p))) * (16'h0008 - s));
  endfunction : ratio
  // m holds data release, word width, late sample, edge, polarity
  task automatic xfer(input logic [1:0] pp, input logic [2:0] sp,
      input logic [4:0] m, input logic [15:0] tx, input logic [15:0] pw);
    logic [15:0] msk;
    logic [15:0] got;
    time t0;
    int n;
    msk = m[3] ? 16'hffff : 16'h00ff;
    cpol <= m[0];
    cke <= m[1];
    word <= m[3] ? pw : {pw[7:0], 8'h00};
    // Let the word settle before the far end loads it on the load edge
    @(posedge core_clk);
    load <= 1'b1;
    wr(`SPF_OFS_FORMAT, {4'h0, m[4:1], 1'b0, m[0], 1'b1, sp, pp});
    load <= 1'b0;
    wr(`SPF_OFS_DATA, tx);
    wait (sck != m[0]);
    t0 = $time;
    wait (sck == m[0]);
    wait (sck != m[0]);
    chk(16'(($time - t0) / 4), ratio(pp, sp));
    @(posedge core_clk);
    n = 0;
    do begin
      rd(`SPF_OFS_STATUS, got);
      n++;
    end while (got[5] && n < 3000);
    chk(rx, m[4] ? msk : tx & msk);
    rd(`SPF_OFS_DATA, got);
    chk(got, pw & msk);
    chk(16'(sck), 16'(m[0]));
  endtask : xfer
  // ==========
  // Main sequence
  initial begin
    logic [15:0] got;
    logic [31:0] r;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(`SPF_OFS_FORMAT, got);
    chk(got, 16'h0000);
    rd(`SPF_OFS_FRAME, got);
    chk(got, 16'h0000);
    wr(`SPF_OFS_FORMAT, 16'hffff);
    rd(`SPF_OFS_FORMAT, got);
    chk(got, 16'h1fff);
    wr(`SPF_OFS_FRAME, 16'hffff);
    rd(`SPF_OFS_FRAME, got);
    chk(got, 16'he003);
    wr(`SPF_OFS_FRAME, 16'h0000);
    wr(`SPF_OFS_STATUS, 16'h8000);
    wr(`SPF_OFS_FORMAT, 16'h1020);
    chk(16'(pin_oe_n.clk), 16'h0001);
    wr(`SPF_OFS_FORMAT, 16'h0020);
    for (int p = 0; p < 2; p++) begin
      wr(`SPF_OFS_FRAME, {2'h2, p[0], 13'h0000});
      @(negedge core_clk);
      chk(16'(pin_oe_n.sel), 16'h0000);
      chk(16'(pin_out.sel), 16'(!p[0]));
      @(posedge core_clk);
    end
    wr(`SPF_OFS_FRAME, 16'h0000);
    xfer(2'h0, 3'h7, 5'h08, 16'ha5c3, 16'h3c5a);
    xfer(2'h2, 3'h5, 5'h13, 16'h0081, 16'h00f0);
    // Random set-ups; halves stay long enough for the input synchroniser
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      xfer(2'h1 + 2'(r[0]), 3'(r[3:1] % 6), r[8:4], r[31:16],
        seed[15:0]);
    end
    close_out();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      close_out();
    end
  end
endmodule : spf_port_bench
`default_nettype wire
